// *** hdl/lvds_framer_pkg.sv ***
// Constants and types shared by the sensor output framer and its bench.
package lvds_framer_pkg;
  localparam int          DATA_LANES     = 32;
  localparam int          WIDE_BITS      = 10;
  localparam int          NARROW_BITS    = 8;
  localparam int          WIN_ID_BITS    = 5;
  localparam int          MIN_LINE_WORDS = 4;
  // Frame sync type field, bits 9:7 of a wide sync word.
  localparam logic [2:0]  TYPE_FRAME_BEGIN = 3'h5;
  localparam logic [2:0]  TYPE_FRAME_FINISH = 3'h6;
  localparam logic [2:0]  TYPE_LINE_BEGIN  = 3'h1;
  localparam logic [2:0]  TYPE_LINE_FINISH = 3'h2;
  // Power-on values software is expected to program into the code ports.
  localparam logic [6:0]  DEF_FRAME_MARKER = 7'h2A;
  localparam logic [9:0]  DEF_BLACK_CLASS  = 10'h015;
  localparam logic [9:0]  DEF_IMAGE_CLASS  = 10'h035;
  localparam logic [9:0]  DEF_CHECK_CLASS  = 10'h059;
  localparam logic [9:0]  DEF_TRAIN_CLASS  = 10'h3A6;
  // A narrow word keeps only bits 9:2 of the ten-bit shift frame.
  localparam logic [9:0]  NARROW_KEEP_MASK = 10'h3FC;
  localparam logic [3:0]  WIDE_LAST_BIT    = 4'h9;
  localparam logic [3:0]  NARROW_LAST_BIT  = 4'h7;
  typedef enum logic [5:0] {
    ST_TRAIN   = 6'h01,
    ST_BEGIN   = 6'h02,
    ST_BEGIN_ID = 6'h04,
    ST_BODY    = 6'h08,
    ST_FINISH  = 6'h10,
    ST_FINISH_ID = 6'h20
  } slot_e;
endpackage

// *** hdl/sensor_lvds_output_framer.sv ***
// Output framer: frames pixel lines with sync codes and serializes 32 data lanes and a sync lane.
`timescale 1ns/1ps
module sensor_lvds_output_framer #(
  parameter int LANES       = lvds_framer_pkg::DATA_LANES,
  parameter int LINE_CNT_W  = 16
) (
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   link_clk_i,
  input  wire logic                   narrow_sel_i,
  input  wire logic [6:0]             frame_marker_i,
  input  wire logic [9:0]             black_pixel_class_i,
  input  wire logic [9:0]             image_class_i,
  input  wire logic [9:0]             training_class_i,
  input  wire logic [9:0]             train_data_i,
  input  wire logic                   line_req_i,
  input  wire logic                   line_black_i,
  input  wire logic [31:0]            win_active_i,
  input  wire logic [31:0]            win_first_i,
  input  wire logic [31:0]            win_last_i,
  input  wire logic [LINE_CNT_W-1:0]  line_words_i,
  input  wire logic [LANES*10-1:0]    pix_data_i,
  output logic                        pix_take_o,
  output logic                        line_busy_o,
  output logic                        clk_out_o,
  output logic [LANES-1:0]            data_lane_o,
  output logic                        sync_lane_o
);
  initial begin
    if (LANES < 1 || LINE_CNT_W < 3) begin
      $error("sensor_lvds_output_framer: unsupported parameters");
    end
  end

  logic [2:0]                link_sync_ff;
  logic [1:0]                narrow_sync_ff;
  logic                      bit_edge;
  logic [3:0]                bit_cnt_ff;
  logic [9:0]                lane_sr_ff [0:LANES];
  logic                      clk_out_ff;
  logic                      pix_take_ff;
  lvds_framer_pkg::slot_e    state_ff;
  lvds_framer_pkg::slot_e    nxt_state;
  logic                      pend_ff;
  logic                      pend_black_ff;
  logic                      pend_first_ff;
  logic                      pend_last_ff;
  logic [4:0]                pend_id_ff;
  logic [LINE_CNT_W-1:0]     pend_words_ff;
  logic                      line_black_ff;
  logic                      line_first_ff;
  logic                      line_last_ff;
  logic [4:0]                line_id_ff;
  logic [LINE_CNT_W-1:0]     line_words_ff;
  logic [LINE_CNT_W-1:0]     word_cnt_ff;
  logic [4:0]                req_id;
  logic [9:0]                nxt_sync_word;
  logic [9:0]                id_word;
  logic [2:0]                begin_type;
  logic [2:0]                finish_type;

  // The link clock is a pin from the host; both of its edges mark one bit each.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      link_sync_ff <= 3'h0;
    end else begin
      link_sync_ff <= {link_sync_ff[1:0], link_clk_i};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      narrow_sync_ff <= 2'h0;
    end else begin
      narrow_sync_ff <= {narrow_sync_ff[0], narrow_sel_i};
    end
  end

  assign bit_edge = link_sync_ff[2] ^ link_sync_ff[1];

  // Highest active window wins, so lower overlapping windows never get codes.
  always_comb begin
    req_id = 5'h00;
    for (int w = 0; w < 32; w++) begin
      if (win_active_i[w]) begin
        req_id = 5'(w);
      end
    end
  end

  // One line is queued at a time; the sequencer waits on line_busy_o.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pend_ff       <= 1'b0;
      pend_black_ff <= 1'b0;
      pend_first_ff <= 1'b0;
      pend_last_ff  <= 1'b0;
      pend_id_ff    <= 5'h00;
      pend_words_ff <= '0;
    end else if (line_req_i && !pend_ff && state_ff == lvds_framer_pkg::ST_TRAIN) begin
      pend_ff       <= 1'b1;
      pend_black_ff <= line_black_i;
      pend_first_ff <= win_first_i[req_id];
      pend_last_ff  <= win_last_i[req_id];
      pend_id_ff    <= req_id;
      // Short lines are stretched to hold begin, id, finish and id.
      pend_words_ff <= (line_words_i < LINE_CNT_W'(lvds_framer_pkg::MIN_LINE_WORDS)) ?
                       LINE_CNT_W'(lvds_framer_pkg::MIN_LINE_WORDS) : line_words_i;
    end else if (bit_edge && bit_cnt_ff == 4'h0 && state_ff == lvds_framer_pkg::ST_TRAIN) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      line_busy_o <= 1'b0;
    end else begin
      line_busy_o <= pend_ff || state_ff != lvds_framer_pkg::ST_TRAIN ||
                     (line_req_i && state_ff == lvds_framer_pkg::ST_TRAIN);
    end
  end

  // Next slot kind, decided once per word boundary.
  always_comb begin
    nxt_state = lvds_framer_pkg::ST_TRAIN;
    case (state_ff)
      lvds_framer_pkg::ST_TRAIN: begin
        nxt_state = pend_ff ? lvds_framer_pkg::ST_BEGIN : lvds_framer_pkg::ST_TRAIN;
      end
      lvds_framer_pkg::ST_BEGIN: begin
        nxt_state = lvds_framer_pkg::ST_BEGIN_ID;
      end
      lvds_framer_pkg::ST_BEGIN_ID, lvds_framer_pkg::ST_BODY: begin
        nxt_state = (word_cnt_ff == line_words_ff - LINE_CNT_W'(2)) ?
                    lvds_framer_pkg::ST_FINISH : lvds_framer_pkg::ST_BODY;
      end
      lvds_framer_pkg::ST_FINISH: begin
        nxt_state = lvds_framer_pkg::ST_FINISH_ID;
      end
      lvds_framer_pkg::ST_FINISH_ID: begin
        nxt_state = lvds_framer_pkg::ST_TRAIN;
      end
      default: begin
        nxt_state = lvds_framer_pkg::ST_TRAIN;
      end
    endcase
  end

  // Begin and finish codes; black lines never use frame codes.
  always_comb begin
    begin_type  = (!line_black_ff && line_first_ff) ? lvds_framer_pkg::TYPE_FRAME_BEGIN :
                  lvds_framer_pkg::TYPE_LINE_BEGIN;
    finish_type = (!line_black_ff && line_last_ff) ? lvds_framer_pkg::TYPE_FRAME_FINISH :
                  lvds_framer_pkg::TYPE_LINE_FINISH;
    if (state_ff == lvds_framer_pkg::ST_TRAIN) begin
      begin_type = (!pend_black_ff && pend_first_ff) ? lvds_framer_pkg::TYPE_FRAME_BEGIN :
                   lvds_framer_pkg::TYPE_LINE_BEGIN;
    end
  end

  // Narrow words occupy bits 9:2 of the shift frame, so the id moves to 8:4.
  assign id_word = narrow_sync_ff[1] ? {1'b0, line_id_ff, 4'h0}
                 : {5'h00, line_id_ff};

  always_comb begin
    case (nxt_state)
      lvds_framer_pkg::ST_BEGIN:     nxt_sync_word = {begin_type, frame_marker_i};
      lvds_framer_pkg::ST_FINISH:    nxt_sync_word = {finish_type, frame_marker_i};
      lvds_framer_pkg::ST_BEGIN_ID,
      lvds_framer_pkg::ST_FINISH_ID: nxt_sync_word = id_word;
      lvds_framer_pkg::ST_BODY: begin
        nxt_sync_word = line_black_ff ? black_pixel_class_i : image_class_i;
      end
      default:                       nxt_sync_word = training_class_i;
    endcase
  end

  // Line bookkeeping advances on each word boundary.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_ff      <= lvds_framer_pkg::ST_TRAIN;
      word_cnt_ff   <= '0;
      line_black_ff <= 1'b0;
      line_first_ff <= 1'b0;
      line_last_ff  <= 1'b0;
      line_id_ff    <= 5'h00;
      line_words_ff <= '0;
    end else if (bit_edge && bit_cnt_ff == 4'h0) begin
      state_ff    <= nxt_state;
      word_cnt_ff <= (nxt_state == lvds_framer_pkg::ST_BEGIN) ? LINE_CNT_W'(1) :
                     word_cnt_ff + LINE_CNT_W'(1);
      if (nxt_state == lvds_framer_pkg::ST_BEGIN) begin
        line_black_ff <= pend_black_ff;
        line_first_ff <= pend_first_ff;
        line_last_ff  <= pend_last_ff;
        line_id_ff    <= pend_id_ff;
        line_words_ff <= pend_words_ff;
      end
    end
  end

  // Shift frames: load a word at the boundary, otherwise shift towards bit 9.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bit_cnt_ff <= 4'h0;
      for (int l = 0; l <= LANES; l++) begin
        lane_sr_ff[l] <= 10'h000;
      end
    end else if (bit_edge) begin
      if (bit_cnt_ff == 4'h0) begin
        bit_cnt_ff <= narrow_sync_ff[1] ? lvds_framer_pkg::NARROW_LAST_BIT :
                      lvds_framer_pkg::WIDE_LAST_BIT;
        for (int l = 0; l < LANES; l++) begin
          // Pixels flow during codes and ids too; training fills idle slots.
          lane_sr_ff[l] <= (nxt_state == lvds_framer_pkg::ST_TRAIN) ? train_data_i :
                           pix_data_i[l*10 +: 10];
        end
        lane_sr_ff[LANES] <= narrow_sync_ff[1] && nxt_state != lvds_framer_pkg::ST_BEGIN_ID &&
                             nxt_state != lvds_framer_pkg::ST_FINISH_ID ?
                             (nxt_sync_word & lvds_framer_pkg::NARROW_KEEP_MASK) :
                             nxt_sync_word;
      end else begin
        bit_cnt_ff <= bit_cnt_ff - 4'h1;
        for (int l = 0; l <= LANES; l++) begin
          lane_sr_ff[l] <= {lane_sr_ff[l][8:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pix_take_ff <= 1'b0;
    end else begin
      pix_take_ff <= bit_edge && bit_cnt_ff == 4'h0 && nxt_state != lvds_framer_pkg::ST_TRAIN;
    end
  end

  // The clock copy is taken in the same cycle the lanes change, matching their delay.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clk_out_ff <= 1'b0;
    end else begin
      clk_out_ff <= link_sync_ff[1];
    end
  end

  assign pix_take_o  = pix_take_ff;
  assign clk_out_o   = clk_out_ff;
  assign sync_lane_o = lane_sr_ff[LANES][9];

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign data_lane_o[g] = lane_sr_ff[g][9];
    end
  endgenerate
endmodule // sensor_lvds_output_framer

// *** tb/framer_monitor.sv ***
// Port-level concurrent checks for the sensor output framer.
`timescale 1ns/1ps
module framer_monitor #(parameter int LANES = 32) (
  input wire logic             clock_i,
  input wire logic             sys_rst_i,
  input wire logic             link_clk_i,
  input wire logic             line_req_i,
  input wire logic             pix_take_o,
  input wire logic             line_busy_o,
  input wire logic             clk_out_o,
  input wire logic [LANES-1:0] data_lane_o,
  input wire logic             sync_lane_o
);
  // Idle cycles since the last line; the tail of a word is still shifting early on.
  logic [7:0] idle_ff;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || line_busy_o) idle_ff <= 8'h00;
    else if (idle_ff != 8'hFF) idle_ff <= idle_ff + 8'h01;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  reset_clear_a: assert property (@(posedge clock_i) disable iff (1'b0)
    sys_rst_i |=> !line_busy_o && !pix_take_o && !clk_out_o && data_lane_o == '0 && !sync_lane_o)
    else $error("outputs not cleared by reset");
  take_spacing_a: assert property (pix_take_o |=> !pix_take_o [*8])
    else $error("pixel take pulses too close");
  take_in_line_a: assert property (pix_take_o |-> $past(line_busy_o))
    else $error("pixel taken outside a line");
  req_accept_a: assert property (line_req_i && idle_ff > 8'h64 |=> line_busy_o)
    else $error("idle line request not taken");
  line_min_a: assert property ($rose(line_busy_o) |-> line_busy_o [*8])
    else $error("line shorter than its framing");
  idle_uniform_a: assert property (idle_ff > 8'h64 |-> data_lane_o == '0 || data_lane_o == '1)
    else $error("lanes differ while training");
  lane_hold_a: assert property ($changed(data_lane_o) || $changed(sync_lane_o)
    |-> clk_out_o != $past(clk_out_o, 2)) else $error("lane moved without a clock edge");
  clk_rise_a: assert property ($rose(link_clk_i) |-> ##[1:5] clk_out_o)
    else $error("forwarded clock missed a rise");
  clk_fall_a: assert property ($fell(link_clk_i) |-> ##[1:5] !clk_out_o)
    else $error("forwarded clock missed a fall");
endmodule // framer_monitor
bind sensor_lvds_output_framer framer_monitor #(.LANES(LANES)) i_framer_monitor (.clock_i,
  .sys_rst_i, .link_clk_i, .line_req_i, .pix_take_o, .line_busy_o, .clk_out_o, .data_lane_o,
  .sync_lane_o);

// *** tb/rx_model.sv ***
// Receiver model: samples all lanes mid-bit on the forwarded clock and keeps the bit history.
`timescale 1ns/1ps
module rx_model (
  input wire logic        clock_i,
  input wire logic        clk_out_i,
  input wire logic [31:0] data_i,
  input wire logic        sync_i
);
  logic        clk_ff;
  logic [2:0]  cnt_ff;
  logic        sync_q[$];
  logic [31:0] data_q[$];
  // Sampling four cycles after each forwarded edge keeps clear of the transition.
  always_ff @(posedge clock_i) begin
    clk_ff <= clk_out_i;
    if (clk_ff !== clk_out_i) cnt_ff <= 3'h0;
    else if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
    if (cnt_ff == 3'h2) begin
      sync_q.push_back(sync_i);
      data_q.push_back(data_i);
    end
  end
  // Word of w bits MSB first from bit p; a negative lane picks the sync lane.
  function automatic logic [9:0] word_at(int p, int w, int lane);
    logic [9:0] v;
    v = 10'h000;
    for (int i = 0; i < w; i++) v = {v[8:0], (lane < 0) ? sync_q[p+i] : data_q[p+i][lane]};
    return v;
  endfunction
endmodule // rx_model

// *** tb/sensor_lvds_output_framer_test.sv ***
// Self-checking bench for the sensor output framer.
`timescale 1ns/1ps
module sensor_lvds_output_framer_test;
  logic         clock_i = 0, sys_rst_i = 1, link_clk_i = 0, narrow_sel_i = 0;
  logic         line_req_i = 0, line_black_i = 0, pix_take_o, line_busy_o, clk_out_o;
  logic         sync_lane_o;
  logic [31:0]  win_active_i = 0, win_first_i = 0, win_last_i = 0, data_lane_o;
  logic [15:0]  line_words_i = 16'h0004;
  logic [319:0] pix_data_i;
  // Training word chosen unlike pixel data.
  logic [9:0]   train_data_i = 10'h2D3;
  logic [6:0]   frame_marker_i = lvds_framer_pkg::DEF_FRAME_MARKER;
  logic [9:0]   image_class_i = lvds_framer_pkg::DEF_IMAGE_CLASS;
  int           bad_count = 0, compares = 0, idx = 0;
  sensor_lvds_output_framer i_sensor_lvds_output_framer (.clock_i, .sys_rst_i, .link_clk_i,
    .narrow_sel_i, .frame_marker_i,
    .black_pixel_class_i(lvds_framer_pkg::DEF_BLACK_CLASS),
    .image_class_i,
    .training_class_i(lvds_framer_pkg::DEF_TRAIN_CLASS), .train_data_i, .line_req_i,
    .line_black_i, .win_active_i, .win_first_i, .win_last_i, .line_words_i, .pix_data_i,
    .pix_take_o, .line_busy_o, .clk_out_o, .data_lane_o, .sync_lane_o);
  rx_model i_rx_model (.clock_i, .clk_out_i(clk_out_o), .data_i(data_lane_o), .sync_i(sync_lane_o));
  function automatic logic [9:0] pix(int k, int l); return 10'(k * 37 + l * 5) ^ 10'h2B5; endfunction
  always_comb for (int l = 0; l < 32; l++) pix_data_i[l*10 +: 10] = pix(idx, l);
  always @(posedge clock_i) #1 if (pix_take_o === 1'b1) idx++;
  initial forever #2 clock_i = ~clock_i;
  // The host clock runs free at a fixed rate, never raised for narrow words.
  initial begin #7; forever #24 link_clk_i = ~link_clk_i; end
  task automatic end_of_test();
    $display("Mismatches %0d, compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run_line(input logic nar, input logic blk, input int n, input logic [31:0] act,
      input logic [31:0] fst, input logic [31:0] lst, input logic [4:0] id,
      input logic [2:0] bt, input logic [2:0] ft);
    int s, p, w, sh;
    logic [9:0] idw, trn, beg;
    w = nar ? 8 : 10;
    sh = nar ? 2 : 0;
    idw = nar ? 10'({1'b0, id, 2'b00}) : 10'(id);
    trn = lvds_framer_pkg::DEF_TRAIN_CLASS >> sh;
    beg = {bt, frame_marker_i} >> sh;
    @(posedge clock_i);
    #1 narrow_sel_i = nar;
    // Acquisition starts only after a long stretch of training for alignment.
    repeat (300) @(posedge clock_i);
    #1 line_black_i = blk;
    line_words_i = 16'(n);
    win_active_i = act;
    win_first_i = fst;
    win_last_i = lst;
    s = i_rx_model.sync_q.size();
    idx = 0;
    line_req_i = 1;
    @(posedge clock_i);
    #1 line_req_i = 0;
    repeat (50) @(posedge clock_i);
    #1 line_req_i = 1;
    @(posedge clock_i);
    #1 line_req_i = 0;
    for (p = 0; line_busy_o !== 1'b0; p++) begin
      if (p > 3000) begin
        bad_count++;
        $display("[ERR] %0t line busy got %h expected %h", $time, line_busy_o, 1'b0);
        end_of_test();
      end
      @(posedge clock_i);
      #1;
    end
    repeat (200) @(posedge clock_i);
    // A bitwise search could lock onto training tail plus code head, so align on words first.
    for (p = s - 2 * w; p < s; p++) if (i_rx_model.word_at(p, w, -1) === trn) break;
    for (int k = 0; k < 30; k++) if (i_rx_model.word_at(p, w, -1) !== beg) p += w;
    chk(i_rx_model.word_at(p - w, w, -1), lvds_framer_pkg::DEF_TRAIN_CLASS >> sh);
    chk(i_rx_model.word_at(p, w, -1), {bt, frame_marker_i} >> sh);
    chk(i_rx_model.word_at(p + w, w, -1), idw);
    for (int k = 2; k < n - 2; k++) chk(i_rx_model.word_at(p + k * w, w, -1),
      (blk ? lvds_framer_pkg::DEF_BLACK_CLASS : image_class_i) >> sh);
    chk(i_rx_model.word_at(p + (n - 2) * w, w, -1), {ft, frame_marker_i} >> sh);
    chk(i_rx_model.word_at(p + (n - 1) * w, w, -1), idw);
    chk(i_rx_model.word_at(p + n * w, w, -1), lvds_framer_pkg::DEF_TRAIN_CLASS >> sh);
    chk(i_rx_model.word_at(p + n * w, w, 0), train_data_i >> sh);
    for (int k = 0; k < n; k++) for (int l = 0; l < 32; l += 31)
      chk(i_rx_model.word_at(p + k * w, w, l), pix(k, l) >> sh);
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    #1 sys_rst_i = 0;
    run_line(0, 0, 6, 32'h0000_000A, 32'h0000_0008, 32'h0000_0000, 5'h03, 3'h5, 3'h2);
    run_line(0, 0, 5, 32'h8000_0001, 32'h0000_0001, 32'h8000_0000, 5'h1F, 3'h1, 3'h6);
    run_line(1, 0, 6, 32'h0000_0010, 32'h0000_0010, 32'h0000_0010, 5'h04, 3'h5, 3'h6);
    run_line(1, 1, 4, 32'h0000_0004, 32'h0000_0004, 32'h0000_0004, 5'h02, 3'h1, 3'h2);
    run_line(0, 1, 7, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 5'h00, 3'h1, 3'h2);
    // Reprogrammed marker and image class must reach the sync lane.
    #1 frame_marker_i = 7'h33;
    image_class_i = 10'h1C7;
    run_line(0, 0, 5, 32'h0000_0200, 32'h0000_0200, 32'h0000_0000, 5'h09, 3'h5, 3'h2);
    end_of_test();
  end
endmodule // sensor_lvds_output_framer_test
